// [bench/cpu_model.sv]
// processor side model: watches reset_out and pulses boot
// assumes it shares clk with the supervisor
`timescale 1ns/100ps
module cpu_model (
    // clock and reset line, active low
    input  wire logic clk,
    input  wire logic reset_out,
    // one-cycle pulse per release
    output logic      boot
);
    logic seen_ff;
    // edge detect, registered so boot never glitches
    always_ff @(posedge clk) begin
        seen_ff <= reset_out;
        boot    <= reset_out & ~seen_ff;
    end
endmodule

// [bench/reset_delay_chk.sv]
// port checker for the reset delay supervisor
// assumes one clock domain and a bind to the top module
`timescale 1ns/100ps
module reset_delay_chk
    import reset_delay_pkg::*;
#(
    parameter reset_delay_pkg::variant_t VARIANT    = VAR_8_128,
    parameter int unsigned               CYC_PER_MS = 40000
) (
    // watched ports
    input wire logic clk,
    input wire logic rst,
    input wire logic uv_flag,
    input wire logic thermal_flag,
    input wire logic delay_select,
    input wire logic reset_out,
    input wire logic out_enable
);
    import reset_delay_pkg::*;
    localparam int SHORT = (VARIANT == VAR_16_64) ? 16 : (VARIANT == VAR_32_128) ? 32 : 8;
    localparam int LONG  = (VARIANT == VAR_8_32) ? 32 : (VARIANT == VAR_16_64) ? 64 : 128;
    localparam int MIN_Q = SHORT * CYC_PER_MS - 2;
    localparam int MAX_Q = LONG * CYC_PER_MS + 4;
    logic [23:0] quiet_ff;
    logic [23:0] nxt_quiet;
    ////////////////////////////////////////////////////////////////
    // cycles since last fault; saturates so long runs never wrap
    always_comb begin
        nxt_quiet = (uv_flag | thermal_flag) ? 24'h0 : quiet_ff + {23'h0, ~&quiet_ff};
    end
    always_ff @(posedge clk) begin
        quiet_ff <= rst ? 24'h0 : nxt_quiet;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    uv_low_a: assert property (uv_flag |=> !reset_out) else $error("uv kept reset high");
    hot_low_a: assert property (thermal_flag |=> !reset_out) else $error("hot kept reset high");
    hot_off_a: assert property (thermal_flag |=> !out_enable) else $error("output on when hot");
    cool_on_a: assert property (!thermal_flag |=> out_enable) else $error("output off when cool");
    early_rise_a: assert property ($rose(reset_out) |-> quiet_ff >= MIN_Q)
        else $error("reset released early");
    late_rise_a: assert property (quiet_ff > MAX_Q |-> reset_out) else $error("release late");
    hold_high_a: assert property (reset_out && !uv_flag && !thermal_flag |=> reset_out)
        else $error("reset dropped without fault");
    init_low_a: assert property ($fell(rst) |-> !reset_out && !out_enable)
        else $error("outputs not low after reset");
endmodule
bind reset_delay_supervisor reset_delay_chk #(.VARIANT(VARIANT), .CYC_PER_MS(CYC_PER_MS)) chk (
    .clk(clk), .rst(rst), .uv_flag(uv_flag), .thermal_flag(thermal_flag),
    .delay_select(delay_select), .reset_out(reset_out), .out_enable(out_enable));

// [bench/reset_delay_supervisor_tb.sv]
// self-checking bench for the reset delay supervisor
// assumes a 4-cycle millisecond so long delays stay brief
`timescale 1ns/100ps
module reset_delay_supervisor_tb;
    import reset_delay_pkg::*;
    localparam int CPM = 4;
    logic clk, rst, uv_flag, thermal_flag, delay_select, reset_out, out_enable, boot;
    int   err_count = 0, comparisons = 0, cyc = 0, seed = 32'h32fd6c29;
    int   exp_q[$];
    reset_delay_supervisor #(.VARIANT(VAR_8_128), .CYC_PER_MS(CPM)) uut (.clk(clk), .rst(rst),
        .uv_flag(uv_flag), .thermal_flag(thermal_flag), .delay_select(delay_select),
        .reset_out(reset_out), .out_enable(out_enable));
    cpu_model cpu (.clk(clk), .reset_out(reset_out), .boot(boot));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////
    // watcher: each boot takes the oldest expected cycle, two cycles slack
    always @(negedge clk) begin
        cyc = cyc + 1;
        if (boot === 1'b1) begin
            comparisons++;
            if (exp_q.size() == 0 || cyc > exp_q[0] + 2 || cyc + 2 < exp_q[0]) begin
                err_count++;
                $display("wrong value at %0t: %h vs %h", $time, cyc, exp_q.size() ? exp_q[0] : 0);
            end
            if (exp_q.size() != 0) void'(exp_q.pop_front());
        end
    end
    // fault for hold edges, release, note the release cycle, wait for it
    task automatic run_fault(input logic u, t, ds, input int hold, d_ms, id);
        int n;
        uv_flag <= u;
        thermal_flag <= t;
        repeat (hold) @(posedge clk);
        delay_select <= ds;
        @(posedge clk);
        {rst, uv_flag, thermal_flag} <= 3'h0;
        exp_q.push_back(cyc + d_ms * CPM + 4);
        n = 0;
        while (exp_q.size() != 0 && n < d_ms * CPM + 20) begin
            @(posedge clk);
            n++;
        end
        $display("test %0d done", id);
    endtask
    task automatic finish_test;
        if (exp_q.size() != 0) err_count++;
        $display("%0d compares, %0d mismatches", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        {rst, uv_flag, thermal_flag, delay_select} = 4'h8;
        @(posedge clk);
        run_fault(1'b0, 1'b0, 1'b0, 8, 8, 1);
        run_fault(1'b1, 1'b0, 1'b1, 3, 128, 2);
        repeat (30) begin
            @(posedge clk);
            delay_select <= 1'($random(seed));
        end
        // select high while reset is high must not reach the next delay
        @(posedge clk);
        delay_select <= 1'b1;
        run_fault(1'b1, 1'b0, 1'b0, 2, 8, 3);
        run_fault(1'b0, 1'b1, 1'b0, 5, 8, 4);
        uv_flag <= 1'b1;
        repeat (3) @(posedge clk);
        uv_flag <= 1'b0;
        repeat (20) @(posedge clk);
        run_fault(1'b1, 1'b0, 1'b0, 2, 8, 5);
        run_fault(1'b1, 1'b1, 1'b1, 1 + ($random(seed) & 7), 128, 6);
        finish_test();
    end
    // hang guard, well past the planned run
    initial begin
        #100000;
        err_count++;
        finish_test();
    end
endmodule

// [hdl/ms_tick_gen.sv]
// millisecond enable pulse from the system clock
// assumes a synchronous active-high reset and the clock rate in the map
`timescale 1ns/100ps
`include "reset_delay_map.svh"
module ms_tick_gen #(
    parameter int unsigned CYC_PER_MS = `CLK_PER_MS
) (
    // clock and reset
    input  wire logic   clk,
    input  wire logic   rst,
    // tick carrier
    ms_tick_if.gen      tk
);
    logic [`MS_CNT_W-1:0] pre_ff;
    logic [`MS_CNT_W-1:0] nxt_pre;
    logic                 tick_ff;
    logic                 nxt_tick;

    ////////////////////////////////////////////////////////////////////////
    // prescaler; cleared when idle so every delay starts a full ms  
    always_comb begin
        nxt_pre  = '0;
        nxt_tick = 1'b0;
        if (tk.run) begin
            if (pre_ff == `MS_CNT_W'(CYC_PER_MS - 1)) begin
                nxt_tick = 1'b1;
            end else begin
                nxt_pre = pre_ff + `MS_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pre_ff  <= '0;
            tick_ff <= 1'b0;
        end else begin
            pre_ff  <= nxt_pre;
            tick_ff <= nxt_tick;
        end
    end

    assign tk.tick = tick_ff & tk.run;
endmodule

// [hdl/ms_tick_if.sv]
// carrier between the supervisor and its millisecond tick generator
// assumes both ends share clk
`timescale 1ns/100ps
interface ms_tick_if;
    logic run;   // prescaler counts while high, clears while low
    logic tick;  // one-cycle pulse per elapsed millisecond

    modport gen (input run, output tick);
    modport use_ (output run, input tick);
endinterface

// [hdl/reset_delay_map.svh]
// constants for the reset delay supervisor: delay menu, clock rate, counts
// assumes a single 40 MHz clock; included by its bare name
`ifndef RESET_DELAY_MAP_SVH
`define RESET_DELAY_MAP_SVH

// clock rate
`define CLK_FREQ_HZ     40000000
`define CLK_PER_MS      (`CLK_FREQ_HZ / 1000)

// delay menu in milliseconds
`define DLY_8_MS        8
`define DLY_16_MS       16
`define DLY_32_MS       32
`define DLY_64_MS       64
`define DLY_128_MS      128

// millisecond prescaler width; 40000 cycles fits in 16 bits
`define MS_CNT_W        16
// millisecond counter width; 128 fits in 8 bits
`define DLY_CNT_W       8

// reset values
`define RESET_OUT_RST   1'b0
`define OUT_EN_RST      1'b0

`endif

// [hdl/reset_delay_pkg.sv]
// types for the reset delay supervisor
// assumes reset_delay_map.svh supplies the numbers
package reset_delay_pkg;

    // build-time delay pairs, short / long
    typedef enum logic [1:0] {
        VAR_8_128,
        VAR_8_32,
        VAR_16_64,
        VAR_32_128
    } variant_t;

    // supervisor states
    typedef enum logic [1:0] {
        ST_FAULT,
        ST_DELAY,
        ST_RUN
    } sup_state_t;

endpackage

// [hdl/reset_delay_supervisor.sv]
// reset delay supervisor: holds the processor reset low on undervoltage or
// overtemperature and releases it after a selectable delay
// assumes flags are synchronous to clk and already debounced by the analog side
`timescale 1ns/100ps
`include "reset_delay_map.svh"
module reset_delay_supervisor
    import reset_delay_pkg::*;
#(
    parameter reset_delay_pkg::variant_t VARIANT    = reset_delay_pkg::VAR_8_128,
    parameter int unsigned               CYC_PER_MS = `CLK_PER_MS
) (
    // clock and reset
    input  wire logic   clk,
    input  wire logic   rst,
    // condition flags
    input  wire logic   uv_flag,
    input  wire logic   thermal_flag,
    // delay choice, low when unconnected
    input  wire logic   delay_select,
    // outputs
    output logic        reset_out,
    output logic        out_enable
);
    import reset_delay_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // delay pair lookup per variant
    function automatic logic [`DLY_CNT_W-1:0] pick_delay(input variant_t v,
                                                        input logic     sel);
        logic [`DLY_CNT_W-1:0] lo;
        logic [`DLY_CNT_W-1:0] hi;
        lo = `DLY_CNT_W'(`DLY_8_MS);
        hi = `DLY_CNT_W'(`DLY_128_MS);
        unique case (v)
            VAR_8_128: begin
                lo = `DLY_CNT_W'(`DLY_8_MS);
                hi = `DLY_CNT_W'(`DLY_128_MS);
            end
            VAR_8_32: begin
                lo = `DLY_CNT_W'(`DLY_8_MS);
                hi = `DLY_CNT_W'(`DLY_32_MS);
            end
            VAR_16_64: begin
                lo = `DLY_CNT_W'(`DLY_16_MS);
                hi = `DLY_CNT_W'(`DLY_64_MS);
            end
            VAR_32_128: begin
                lo = `DLY_CNT_W'(`DLY_32_MS);
                hi = `DLY_CNT_W'(`DLY_128_MS);
            end
        endcase
        return sel ? hi : lo;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // one more millisecond; never passes the longest delay, so no wrap
    function automatic logic [`DLY_CNT_W-1:0] ms_plus_one(input logic [`DLY_CNT_W-1:0] ms);
        return ms + `DLY_CNT_W'(1);
    endfunction

    // true when the tick now arriving completes the latched delay
    function automatic logic delay_reached(input logic [`DLY_CNT_W-1:0] ms,
                                           input logic [`DLY_CNT_W-1:0] target);
        return ms_plus_one(ms) >= target;
    endfunction

    ms_tick_if tk ();

    ms_tick_gen #(
        .CYC_PER_MS (CYC_PER_MS)
    ) u_tick (
        .clk (clk),
        .rst (rst),
        .tk  (tk)
    );

    // supervisor state
    sup_state_t            state_ff;
    sup_state_t            nxt_state;

    // whole milliseconds counted in the current delay window
    logic [`DLY_CNT_W-1:0] ms_ff;
    logic [`DLY_CNT_W-1:0] nxt_ms;

    // delay length latched from delay_select while reset is low
    logic [`DLY_CNT_W-1:0] target_ff;
    logic [`DLY_CNT_W-1:0] nxt_target;

    // registered pin drivers
    logic                  reset_out_ff;
    logic                  nxt_reset_out;
    logic                  out_en_ff;
    logic                  nxt_out_en;

    // decoded conditions
    logic                  fault;
    logic                  delay_done;

    ////////////////////////////////////////////////////////////////////////
    // either flag counts as a fault; both hold reset low at once
    assign fault      = uv_flag | thermal_flag;
    // the tick now arriving ends the window
    assign delay_done = tk.tick & delay_reached(ms_ff, target_ff);

    // prescaler only runs during a clean delay window, so a fault part way
    // through also throws away the partly counted millisecond
    assign tk.run = (state_ff == ST_DELAY) & ~fault;

    ////////////////////////////////////////////////////////////////////////
    // state next value; the spare code cannot be reached but falls back to fault
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_FAULT: begin
                if (!fault) begin
                    nxt_state = ST_DELAY;
                end
            end
            ST_DELAY: begin
                if (fault) begin
                    nxt_state = ST_FAULT;
                end else if (delay_done) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (fault) begin
                    nxt_state = ST_FAULT;
                end
            end
            default: begin
                nxt_state = ST_FAULT;
            end
        endcase
    end

    // power-on reset starts in the fault state
    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= ST_FAULT;
        end else begin
            state_ff <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // millisecond count; cleared whenever the window is broken or over,
    // so every new window starts from zero whatever came before
    always_comb begin
        nxt_ms = ms_ff;
        if (state_ff != ST_DELAY || fault) begin
            nxt_ms = '0;
        end else if (tk.tick && !delay_done) begin
            nxt_ms = ms_plus_one(ms_ff);
        end
    end

    // counter starts clear
    always_ff @(posedge clk) begin
        if (rst) begin
            ms_ff <= '0;
        end else begin
            ms_ff <= nxt_ms;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // delay choice follows delay_select while reset is low and freezes while
    // it is high, so a select change then waits for the next fault
    always_comb begin
        nxt_target = target_ff;
        if (!reset_out_ff) begin
            nxt_target = pick_delay(VARIANT, delay_select);
        end
    end

    // any menu value will do here; replaced on the first cycle out of reset
    always_ff @(posedge clk) begin
        if (rst) begin
            target_ff <= `DLY_CNT_W'(`DLY_8_MS);
        end else begin
            target_ff <= nxt_target;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin drivers; reset follows the state, output enable only the thermal
    // flag, since an undervoltage leaves the pass device on
    always_comb begin
        nxt_reset_out = 1'b0;
        nxt_out_en    = ~thermal_flag;
        unique case (state_ff)
            ST_FAULT: begin
                nxt_reset_out = 1'b0;
            end
            ST_DELAY: begin
                nxt_reset_out = delay_done;
            end
            ST_RUN: begin
                nxt_reset_out = ~fault;
            end
            default: begin
                nxt_reset_out = 1'b0;
            end
        endcase
    end

    // reset starts low and the output off until the flags have been seen
    always_ff @(posedge clk) begin
        if (rst) begin
            reset_out_ff <= `RESET_OUT_RST;
            out_en_ff    <= `OUT_EN_RST;
        end else begin
            reset_out_ff <= nxt_reset_out;
            out_en_ff    <= nxt_out_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs straight from their flip-flops
    assign reset_out  = reset_out_ff;
    assign out_enable = out_en_ff;
endmodule
